// ---- logic/fecs_array.sv ----
// Small flash array model with registered read data
`timescale 1ns/1ps
module fecs_array #(
  parameter int unsigned AW = 12,
  parameter int unsigned DW = 16
) (
  input  wire logic          ref_clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_r [2**AW];

  always_ff @(posedge ref_clk_i)
  begin
    if (we_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end
endmodule

// ---- logic/fecs_pkg.sv ----
// Constants and types shared by the flash erase command sequencer
// Summary of operation
// - Sector erase: AA, 55, 80, AA, 55, then 30 at sector; more 30s add sectors
// - Chip erase: AA, 55, 80 at 555h, AA, 55, then 10 at 555h
// - Embedded erase first programs every target location to zero, then erases
// - After chip erase every location reads FFFFh
// - Erase runs with no host timing beyond the command writes
// - On completion the bank returns to read mode, addresses released
// - Progress shown by completion polarity bit or toggle plus erase toggle
// - All commands ignored while a chip erase runs
// - Reset aborts erase at once; host reissues the sequence afterwards
// - Suspend during acceptance window ends window and suspends at once
// - Suspend accepted only for sector erase; ignored during chip erase
// - Suspend after the window halts erase within the suspend latency
// - Suspended: reads and programs allowed outside the selected sectors
// - Reads inside a suspended sector return status on the low byte
// - Status bits tell actively erasing from erase suspended
// - Program during suspend returns to suspend-read, normal program status
// - Autoselect accepted while in erase-suspend-read mode
// - Resume code 30h restarts erase; extra resumes ignored; resuspend allowed
// - Other commands in the acceptance window return the bank to read
// - Window starts at final write; window expired bit shows it elapsed
// - Once erasing, only suspend is acted upon
// - After sector erase every location of erased sectors reads FFFFh
package fecs_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned SECT_W = 4;
  localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h2AA;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] SETUP_DATA   = 16'h0080;
  localparam logic [15:0] SECT_ER_DATA = 16'h0030;
  localparam logic [15:0] CHIP_ER_DATA = 16'h0010;
  localparam logic [15:0] SUSPEND_DATA = 16'h00B0;
  localparam logic [15:0] RESUME_DATA  = 16'h0030;
  localparam logic [15:0] AUTOSEL_DATA = 16'h0090;
  localparam logic [15:0] PROGRAM_DATA = 16'h00A0;
  localparam logic [15:0] RESET_DATA   = 16'h00F0;
  localparam logic [15:0] ERASED_WORD  = 16'hFFFF;
  localparam logic [15:0] ZERO_WORD    = 16'h0000;
  localparam int unsigned CLK_NS       = 100;
  localparam int unsigned ACCEPT_US    = 50;
  localparam int unsigned LATENCY_US   = 20;
  localparam int unsigned GAP_US       = 100;
  localparam int unsigned ACCEPT_CYC   = (ACCEPT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LATENCY_CYC  = (LATENCY_US * 1000) / CLK_NS;
  localparam int unsigned GAP_CYC      = (GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PROG_CYC     = 4;
  localparam int unsigned POLARITY_BIT = 7;
  localparam int unsigned TOGGLE_BIT   = 6;
  localparam int unsigned EXPIRED_BIT  = 3;
  localparam int unsigned ETOGGLE_BIT  = 2;
  typedef enum logic [2:0] {
    FECS_CMD_IDLE, FECS_CMD_U1, FECS_CMD_U2, FECS_CMD_SETUP, FECS_CMD_U4, FECS_CMD_U5
  } fecs_cmd_e;
  typedef enum logic [3:0] {
    FECS_READ, FECS_WINDOW, FECS_PREPROG, FECS_ERASE, FECS_SUSP_PEND,
    FECS_SUSPENDED, FECS_SUSP_PROG, FECS_AUTOSEL
  } fecs_op_e;
endpackage

// ---- logic/fecs_timer.sv ----
// Down counter for window, latency and gap timing
`timescale 1ns/1ps
module fecs_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (load_i)
    begin
      cnt_nxt = count_i;
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_o = (cnt_r == '0) && !load_i;
endmodule

// ---- logic/fecs_top.sv ----
// Erase command decoder, embedded erase and suspend control
`timescale 1ns/1ps
module fecs_top #(
  parameter int unsigned ACCEPT_CYC  = fecs_pkg::ACCEPT_CYC,
  parameter int unsigned LATENCY_CYC = fecs_pkg::LATENCY_CYC,
  parameter int unsigned GAP_CYC     = fecs_pkg::GAP_CYC,
  parameter int unsigned SECT_W      = fecs_pkg::SECT_W
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        reset_i,
  input  wire logic                        we_n_i,
  input  wire logic                        oe_n_i,
  input  wire logic [fecs_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [15:0]                 data_i,
  output logic      [15:0]                 data_o,
  output logic                             busy_o,
  output logic                             suspended_o,
  output logic                             window_expired_o
);
  localparam int unsigned AW   = fecs_pkg::ADDR_W;
  localparam int unsigned OW   = AW - SECT_W;
  localparam int unsigned NSEC = 2 ** SECT_W;

  function automatic logic [SECT_W-1:0] sect_of(input logic [AW-1:0] a);
    return a[AW-1 -: SECT_W];
  endfunction

  function automatic logic [15:0] status_word(input logic pol, input logic tg,
                                              input logic ex, input logic et);
    logic [15:0] s;
    s                          = fecs_pkg::ZERO_WORD;
    s[fecs_pkg::POLARITY_BIT]  = pol;
    s[fecs_pkg::TOGGLE_BIT]    = tg;
    s[fecs_pkg::EXPIRED_BIT]   = ex;
    s[fecs_pkg::ETOGGLE_BIT]   = et;
    return s;
  endfunction

  // Pin synchronisers
  logic          we_s1_r, we_s2_r, we_s3_r, oe_s1_r, oe_s2_r, oe_s3_r;
  logic [AW-1:0] addr_s1_r, addr_s2_r;
  logic [15:0]   data_s1_r, data_s2_r;
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      we_s1_r   <= 1'b1;
      we_s2_r   <= 1'b1;
      we_s3_r   <= 1'b1;
      oe_s1_r   <= 1'b1;
      oe_s2_r   <= 1'b1;
      oe_s3_r   <= 1'b1;
      addr_s1_r <= '0;
      addr_s2_r <= '0;
      data_s1_r <= '0;
      data_s2_r <= '0;
    end
    else
    begin
      we_s1_r   <= we_n_i;
      we_s2_r   <= we_s1_r;
      we_s3_r   <= we_s2_r;
      oe_s1_r   <= oe_n_i;
      oe_s2_r   <= oe_s1_r;
      oe_s3_r   <= oe_s2_r;
      addr_s1_r <= addr_i;
      addr_s2_r <= addr_s1_r;
      data_s1_r <= data_i;
      data_s2_r <= data_s1_r;
    end
  end
  // Write taken at the rising edge of the strobe
  logic wr;
  assign wr = we_s2_r && !we_s3_r;
  logic is_u1, is_u2;
  assign is_u1 = addr_s2_r == fecs_pkg::UNLOCK1_ADDR && data_s2_r == fecs_pkg::UNLOCK1_DATA;
  assign is_u2 = addr_s2_r == fecs_pkg::UNLOCK2_ADDR && data_s2_r == fecs_pkg::UNLOCK2_DATA;

  fecs_pkg::fecs_cmd_e cmd_r, cmd_nxt;
  fecs_pkg::fecs_op_e  op_r, op_nxt;
  logic [NSEC-1:0] sel_r, sel_nxt;
  logic [OW-1:0]   pos_r, pos_nxt;
  logic            chip_r, chip_nxt, tog_r, tog_nxt, etog_r, etog_nxt, exp_r, exp_nxt;
  logic            prog_r, prog_nxt;
  logic [AW-1:0]   paddr_r, paddr_nxt;
  logic [15:0]     pdata_r, pdata_nxt;
  logic [2:0]      pcnt_r, pcnt_nxt;
  logic            t_load;
  logic [15:0]     t_count;
  logic            t_done;
  logic            g_load;
  logic            g_done;
  logic            mem_we;
  logic [AW-1:0]   mem_wa;
  logic [15:0]     mem_wd;
  logic [15:0]     mem_rd;
  logic [SECT_W-1:0] cur_sect;
  logic            in_sel, rd_edge;

  fecs_timer #(.W(16)) u_timer (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .load_i    (t_load),
    .count_i   (t_count),
    .done_o    (t_done)
  );
  fecs_timer #(.W(16)) u_gap (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .load_i    (g_load),
    .count_i   (16'(GAP_CYC)),
    .done_o    (g_done)
  );
  fecs_array #(.AW(AW), .DW(16)) u_array (
    .ref_clk_i (ref_clk_i),
    .we_i      (mem_we),
    .waddr_i   (mem_wa),
    .wdata_i   (mem_wd),
    .raddr_i   (addr_s2_r),
    .rdata_o   (mem_rd)
  );

  assign cur_sect = sect_of(addr_s2_r);
  assign in_sel   = sel_r[cur_sect];
  assign rd_edge  = oe_s3_r && !oe_s2_r;

  always_comb
  begin
    cmd_nxt   = cmd_r;
    op_nxt    = op_r;
    sel_nxt   = sel_r;
    pos_nxt   = pos_r;
    chip_nxt  = chip_r;
    exp_nxt   = exp_r;
    prog_nxt  = prog_r;
    paddr_nxt = paddr_r;
    pdata_nxt = pdata_r;
    pcnt_nxt  = pcnt_r;
    tog_nxt   = tog_r;
    etog_nxt  = etog_r;
    t_load    = 1'b0;
    t_count   = 16'(ACCEPT_CYC);
    g_load    = 1'b0;
    mem_we    = 1'b0;
    mem_wa    = {cur_sect, pos_r};
    mem_wd    = fecs_pkg::ZERO_WORD;
    // Toggle bit flips on each read while busy or programming in suspend; erase toggle on reads of selected sectors while busy or suspend-read
    if (rd_edge)
    begin
      if (op_r inside {fecs_pkg::FECS_WINDOW, fecs_pkg::FECS_PREPROG, fecs_pkg::FECS_ERASE,
                       fecs_pkg::FECS_SUSP_PEND})
      begin
        tog_nxt  = !tog_r;
        etog_nxt = in_sel ? !etog_r : etog_r;
      end
      else if (op_r == fecs_pkg::FECS_SUSPENDED && in_sel)
      begin
        etog_nxt = !etog_r;
      end
      else if (op_r == fecs_pkg::FECS_SUSP_PROG)
      begin
        tog_nxt = !tog_r;
      end
    end
    // Unlock prefix decoder, shared by both erases
    if (wr && op_r inside {fecs_pkg::FECS_READ, fecs_pkg::FECS_SUSPENDED})
    begin
      unique case (cmd_r)
        fecs_pkg::FECS_CMD_IDLE:  cmd_nxt = is_u1 ? fecs_pkg::FECS_CMD_U1 : fecs_pkg::FECS_CMD_IDLE;
        fecs_pkg::FECS_CMD_U1:    cmd_nxt = is_u2 ? fecs_pkg::FECS_CMD_U2 : fecs_pkg::FECS_CMD_IDLE;
        fecs_pkg::FECS_CMD_U2:    cmd_nxt = (addr_s2_r == fecs_pkg::UNLOCK1_ADDR &&
                                             data_s2_r == fecs_pkg::SETUP_DATA &&
                                             op_r == fecs_pkg::FECS_READ) ?
                                            fecs_pkg::FECS_CMD_SETUP : fecs_pkg::FECS_CMD_IDLE;
        fecs_pkg::FECS_CMD_SETUP: cmd_nxt = is_u1 ? fecs_pkg::FECS_CMD_U4 : fecs_pkg::FECS_CMD_IDLE;
        fecs_pkg::FECS_CMD_U4:    cmd_nxt = is_u2 ? fecs_pkg::FECS_CMD_U5 : fecs_pkg::FECS_CMD_IDLE;
        fecs_pkg::FECS_CMD_U5:    cmd_nxt = fecs_pkg::FECS_CMD_IDLE;
      endcase
    end
    unique case (op_r)
      fecs_pkg::FECS_READ:
      begin
        if (wr && cmd_r == fecs_pkg::FECS_CMD_U5 && data_s2_r == fecs_pkg::SECT_ER_DATA)
        begin
          op_nxt  = fecs_pkg::FECS_WINDOW;
          sel_nxt = '0;
          sel_nxt[cur_sect] = 1'b1;
          chip_nxt = 1'b0;
          exp_nxt  = 1'b0;
          t_load   = 1'b1;
        end
        else if (wr && cmd_r == fecs_pkg::FECS_CMD_U5 && data_s2_r == fecs_pkg::CHIP_ER_DATA
                 && addr_s2_r == fecs_pkg::UNLOCK1_ADDR)
        begin
          op_nxt   = fecs_pkg::FECS_PREPROG;
          sel_nxt  = '1;
          chip_nxt = 1'b1;
          exp_nxt  = 1'b1;
          pos_nxt  = '0;
        end
      end
      fecs_pkg::FECS_WINDOW:
      begin
        if (wr && data_s2_r == fecs_pkg::SECT_ER_DATA)
        begin
          sel_nxt[cur_sect] = 1'b1;
          t_load = 1'b1;
        end
        else if (wr && data_s2_r == fecs_pkg::SUSPEND_DATA)
        begin
          op_nxt = fecs_pkg::FECS_SUSPENDED;
          pos_nxt = '0;
        end
        else if (wr)
        begin
          op_nxt  = fecs_pkg::FECS_READ;
          sel_nxt = '0;
        end
        else if (t_done)
        begin
          op_nxt  = fecs_pkg::FECS_PREPROG;
          exp_nxt = 1'b1;
          pos_nxt = '0;
        end
      end
      fecs_pkg::FECS_PREPROG, fecs_pkg::FECS_ERASE:
      begin
        // Walk every word of every selected sector, zero pass then erase pass
        mem_we = 1'b1;
        mem_wa = {sect_of(paddr_r), pos_r};
        mem_wd = (op_r == fecs_pkg::FECS_PREPROG) ? fecs_pkg::ZERO_WORD
                                                   : fecs_pkg::ERASED_WORD;
        if (!sel_r[sect_of(paddr_r)])
        begin
          mem_we = 1'b0;
        end
        if (pos_r == '1)
        begin
          paddr_nxt = {sect_of(paddr_r) + SECT_W'(1), OW'(0)};
          if (sect_of(paddr_r) == '1)
          begin
            op_nxt = (op_r == fecs_pkg::FECS_PREPROG) ? fecs_pkg::FECS_ERASE
                                                       : fecs_pkg::FECS_READ;
            if (op_r == fecs_pkg::FECS_ERASE)
            begin
              sel_nxt = '0;
              chip_nxt = 1'b0;
            end
          end
        end
        pos_nxt = pos_r + OW'(1);
        if (wr && data_s2_r == fecs_pkg::SUSPEND_DATA && !chip_r)
        begin
          op_nxt  = fecs_pkg::FECS_SUSP_PEND;
          t_load  = 1'b1;
          t_count = 16'(LATENCY_CYC);
          pos_nxt = pos_r;
          paddr_nxt = paddr_r;
        end
      end
      fecs_pkg::FECS_SUSP_PEND:
      begin
        if (t_done)
        begin
          op_nxt = fecs_pkg::FECS_SUSPENDED;
        end
      end
      fecs_pkg::FECS_SUSPENDED:
      begin
        if (wr && prog_r)
        begin
          prog_nxt = 1'b0;
          if (!sel_r[cur_sect])
          begin
            op_nxt    = fecs_pkg::FECS_SUSP_PROG;
            paddr_nxt = addr_s2_r;
            pdata_nxt = data_s2_r;
            pcnt_nxt  = 3'(fecs_pkg::PROG_CYC);
          end
        end
        else if (wr && cmd_r == fecs_pkg::FECS_CMD_U2 && data_s2_r == fecs_pkg::PROGRAM_DATA)
        begin
          prog_nxt = 1'b1;
        end
        else if (wr && cmd_r == fecs_pkg::FECS_CMD_U2 && data_s2_r == fecs_pkg::AUTOSEL_DATA)
        begin
          op_nxt = fecs_pkg::FECS_AUTOSEL;
        end
        else if (wr && cmd_r == fecs_pkg::FECS_CMD_IDLE && data_s2_r == fecs_pkg::RESUME_DATA)
        begin
          op_nxt = fecs_pkg::FECS_PREPROG;
          exp_nxt = 1'b1;
          g_load = 1'b1;
        end
      end
      fecs_pkg::FECS_SUSP_PROG:
      begin
        if (pcnt_r == 3'h0)
        begin
          mem_we   = 1'b1;
          mem_wa   = paddr_r;
          mem_wd   = pdata_r;
          op_nxt   = fecs_pkg::FECS_SUSPENDED;
          paddr_nxt = '0;
        end
        else
        begin
          pcnt_nxt = pcnt_r - 3'h1;
        end
      end
      fecs_pkg::FECS_AUTOSEL:
      begin
        if (wr && data_s2_r == fecs_pkg::RESET_DATA)
        begin
          op_nxt = fecs_pkg::FECS_SUSPENDED;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      cmd_r   <= fecs_pkg::FECS_CMD_IDLE;
      op_r    <= fecs_pkg::FECS_READ;
      sel_r   <= '0;
      pos_r   <= '0;
      chip_r  <= 1'b0;
      exp_r   <= 1'b0;
      prog_r  <= 1'b0;
      paddr_r <= '0;
      pdata_r <= '0;
      pcnt_r  <= '0;
      tog_r   <= 1'b0;
      etog_r  <= 1'b0;
    end
    else
    begin
      cmd_r   <= cmd_nxt;
      op_r    <= op_nxt;
      sel_r   <= sel_nxt;
      pos_r   <= pos_nxt;
      chip_r  <= chip_nxt;
      exp_r   <= exp_nxt;
      prog_r  <= prog_nxt;
      paddr_r <= paddr_nxt;
      pdata_r <= pdata_nxt;
      pcnt_r  <= pcnt_nxt;
      tog_r   <= tog_nxt;
      etog_r  <= etog_nxt;
    end
  end

  // Read data: status inside busy or suspended sectors and at the address being programmed, array elsewhere
  logic [15:0] dout_nxt;
  logic        busy_any;
  assign busy_any = op_r inside {fecs_pkg::FECS_WINDOW, fecs_pkg::FECS_PREPROG,
                                 fecs_pkg::FECS_ERASE, fecs_pkg::FECS_SUSP_PEND};
  always_comb
  begin
    dout_nxt = mem_rd;
    if (busy_any && (in_sel || chip_r))
    begin
      dout_nxt = status_word(1'b0, tog_r, exp_r, etog_r);
    end
    else if (op_r == fecs_pkg::FECS_SUSPENDED && in_sel)
    begin
      dout_nxt = status_word(1'b1, tog_r, exp_r, etog_r);
    end
    else if (op_r == fecs_pkg::FECS_SUSP_PROG && addr_s2_r == paddr_r)
    begin
      dout_nxt = status_word(!pdata_r[fecs_pkg::POLARITY_BIT], tog_r, 1'b0, 1'b0);
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      data_o           <= '0;
      busy_o           <= 1'b0;
      suspended_o      <= 1'b0;
      window_expired_o <= 1'b0;
    end
    else
    begin
      data_o           <= dout_nxt;
      busy_o           <= busy_any || op_r == fecs_pkg::FECS_SUSP_PROG;
      suspended_o      <= op_r inside {fecs_pkg::FECS_SUSPENDED, fecs_pkg::FECS_SUSP_PROG,
                                       fecs_pkg::FECS_AUTOSEL};
      window_expired_o <= exp_r;
    end
  end

  // Suspend taken to suspended: one cycle into pending, the latency, then one registering cycle
  localparam int LAT_MAX = int'(LATENCY_CYC) + 2;

  sequence erase_done_s;
    op_r == fecs_pkg::FECS_ERASE ##1 op_r == fecs_pkg::FECS_READ;
  endsequence

  chip_ignores_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    chip_r && op_r inside {fecs_pkg::FECS_PREPROG, fecs_pkg::FECS_ERASE}
    |=> op_r != fecs_pkg::FECS_SUSP_PEND)
    else $error("suspend acted on during chip erase");
  window_suspend_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_r == fecs_pkg::FECS_WINDOW && wr && data_s2_r == fecs_pkg::SUSPEND_DATA
    |=> op_r == fecs_pkg::FECS_SUSPENDED)
    else $error("window suspend not immediate");
  window_other_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_r == fecs_pkg::FECS_WINDOW && wr && data_s2_r != fecs_pkg::SUSPEND_DATA
    && data_s2_r != fecs_pkg::SECT_ER_DATA |=> op_r == fecs_pkg::FECS_READ)
    else $error("stray command kept window");
  suspend_latency_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_r inside {fecs_pkg::FECS_PREPROG, fecs_pkg::FECS_ERASE} && wr
    && data_s2_r == fecs_pkg::SUSPEND_DATA && !chip_r
    |-> ##[1:LAT_MAX] op_r == fecs_pkg::FECS_SUSPENDED)
    else $error("suspend latency exceeded");
  done_read_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    erase_done_s |-> sel_r == '0)
    else $error("addresses still latched after erase");
  resume_gap_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    op_r == fecs_pkg::FECS_SUSPENDED && wr && !prog_r && cmd_r == fecs_pkg::FECS_CMD_IDLE
    && data_s2_r == fecs_pkg::RESUME_DATA |=> !g_done)
    else $error("resume gap timer not started");
  expired_out_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(exp_r) |=> window_expired_o)
    else $error("expired bit not shown");
endmodule

// ---- tb/fecs_host.sv ----
// Host controller model issuing flash command write and read cycles
`timescale 1ns/1ps
module fecs_host (
  input  wire logic        ref_clk_i,
  input  wire logic [15:0] rd_data_i,
  output logic             we_n_o,
  output logic             oe_n_o,
  output logic      [11:0] addr_o,
  output logic      [15:0] data_o
);
  initial
  begin
    we_n_o = 1'b1;
    oe_n_o = 1'b1;
    addr_o = 12'h000;
    data_o = 16'h0000;
  end

  // Strobe two cycles, hold address and data past the sync window
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    #1;
    addr_o = a;
    data_o = d;
    we_n_o = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    we_n_o = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    data_o = ~d;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    #1;
    addr_o = a;
    oe_n_o = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    #1;
    d = rd_data_i;
    oe_n_o = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic unlock();
    wr(12'h555, 16'h00AA);
    wr(12'h2AA, 16'h0055);
  endtask

  // Full six-write erase sequence, last write carries the erase code
  task automatic seq6(input logic [11:0] a, input logic [15:0] d);
    unlock();
    wr(12'h555, 16'h0080);
    unlock();
    wr(a, d);
  endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the flash erase command sequencer
`timescale 1ns/1ps
module tb;
  localparam int unsigned ACC = 20;
  localparam int unsigned LAT = 5;
  localparam int unsigned GAP = 10;
  logic        ref_clk_i;
  logic        reset_i;
  logic        we_n;
  logic        oe_n;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        busy;
  logic        susp;
  logic        expd;
  logic [15:0] v;
  logic [15:0] w;
  logic [15:0] pd;
  logic [11:0] pa;
  int          seed;
  int          miscompares;
  int          n_checks;

  fecs_top #(.ACCEPT_CYC(ACC), .LATENCY_CYC(LAT), .GAP_CYC(GAP)) i_fecs_top (
    .ref_clk_i        (ref_clk_i),
    .reset_i          (reset_i),
    .we_n_i           (we_n),
    .oe_n_i           (oe_n),
    .addr_i           (addr),
    .data_i           (wdata),
    .data_o           (rdata),
    .busy_o           (busy),
    .suspended_o      (susp),
    .window_expired_o (expd)
  );
  fecs_host i_fecs_host (
    .ref_clk_i (ref_clk_i),
    .rd_data_i (rdata),
    .we_n_o    (we_n),
    .oe_n_o    (oe_n),
    .addr_o    (addr),
    .data_o    (wdata)
  );

  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [15:0] fl(input logic b, input logic s);
    return {14'h0000, b, s};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk(fl(busy, susp), fl(1'b0, 1'b0));
  endtask

  // Read a random word of a sector and expect the erased value
  task automatic chk_erased(input logic [3:0] s);
    w = 16'($random(seed));
    i_fecs_host.rd({s, w[7:0]}, v);
    chk(v, fecs_pkg::ERASED_WORD);
  endtask

  initial
  begin
    #9000000;
    miscompares++;
    print_verdict();
  end

  initial
  begin
    seed = 92;
    miscompares = 0;
    n_checks = 0;
    reset_i = 1'b1;
    repeat (16) @(posedge ref_clk_i);
    #1;
    chk(fl(busy, susp), fl(1'b0, 1'b0));
    reset_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    // Single sector erase with status polling mid-run
    i_fecs_host.seq6(12'h200, 16'h0030);
    chk(fl(busy, expd), fl(1'b1, 1'b0));
    repeat (ACC + 4) @(posedge ref_clk_i);
    #1;
    chk(fl(busy, expd), fl(1'b1, 1'b1));
    i_fecs_host.rd(12'h210, v);
    i_fecs_host.rd(12'h210, w);
    chk(fl(v[7], v[6] ^ w[6]), fl(1'b0, 1'b1));
    i_fecs_host.wr(12'h000, 16'h00F0);
    chk(fl(busy, susp), fl(1'b1, 1'b0));
    wait_idle();
    chk_erased(4'h2);
    // Second sector added inside the window
    i_fecs_host.seq6(12'h400, 16'h0030);
    i_fecs_host.wr(12'h7C0, 16'h0030);
    wait_idle();
    chk_erased(4'h4);
    chk_erased(4'h7);
    // Foreign command inside the window cancels the erase
    i_fecs_host.seq6(12'h800, 16'h0030);
    i_fecs_host.wr(12'h555, 16'h00F0);
    chk(fl(busy, susp), fl(1'b0, 1'b0));
    // Suspend inside the window, then work in suspend-read mode
    i_fecs_host.seq6(12'h600, 16'h0030);
    i_fecs_host.wr(12'h600, 16'h00B0);
    chk(fl(busy, susp), fl(1'b0, 1'b1));
    i_fecs_host.rd(12'h630, v);
    i_fecs_host.rd(12'h630, w);
    chk(fl(v[7], v[2] ^ w[2]), fl(1'b1, 1'b1));
    w = 16'($random(seed));
    pa = {4'h9, w[7:0]};
    pd = 16'($random(seed));
    i_fecs_host.unlock();
    i_fecs_host.wr(12'h555, 16'h00A0);
    i_fecs_host.wr(pa, pd);
    repeat (8) @(posedge ref_clk_i);
    #1;
    chk(fl(busy, susp), fl(1'b0, 1'b1));
    i_fecs_host.rd(pa, v);
    chk(v, pd);
    i_fecs_host.unlock();
    i_fecs_host.wr(12'h555, 16'h0090);
    chk(fl(busy, susp), fl(1'b0, 1'b1));
    // Resume code has no effect while identification mode is open
    i_fecs_host.wr(12'h600, 16'h0030);
    chk(fl(busy, susp), fl(1'b0, 1'b1));
    i_fecs_host.wr(12'h000, 16'h00F0);
    chk(fl(busy, susp), fl(1'b0, 1'b1));
    i_fecs_host.wr(12'h600, 16'h0030);
    chk(fl(busy, susp), fl(1'b1, 1'b0));
    i_fecs_host.wr(12'h600, 16'h0030);
    chk(fl(busy, susp), fl(1'b1, 1'b0));
    repeat (GAP + ACC) @(posedge ref_clk_i);
    // Suspend once the window is over, bounded by the latency
    i_fecs_host.wr(12'h600, 16'h00B0);
    repeat (LAT + 2) @(posedge ref_clk_i);
    #1;
    chk(fl(busy, susp), fl(1'b0, 1'b1));
    i_fecs_host.wr(12'h600, 16'h0030);
    wait_idle();
    chk_erased(4'h6);
    i_fecs_host.rd(pa, v);
    chk(v, pd);
    // Chip erase ignores a suspend command
    i_fecs_host.seq6(12'h555, 16'h0010);
    i_fecs_host.wr(12'h600, 16'h00B0);
    repeat (LAT + 4) @(posedge ref_clk_i);
    #1;
    chk(fl(busy, susp), fl(1'b1, 1'b0));
    wait_idle();
    for (int i = 0; i < 4; i++)
    begin
      w = 16'($random(seed));
      chk_erased(w[3:0]);
    end
    // Reset aborts a running erase, then the host reissues it
    i_fecs_host.seq6(12'h300, 16'h0030);
    repeat (ACC + 4) @(posedge ref_clk_i);
    #1;
    reset_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk(fl(busy, susp), fl(1'b0, 1'b0));
    reset_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(fl(busy, susp), fl(1'b0, 1'b0));
    i_fecs_host.seq6(12'h300, 16'h0030);
    wait_idle();
    chk_erased(4'h3);
    print_verdict();
  end
endmodule
